/* File: rtl/vcr_i2c_bank.sv */
`timescale 1ns/1ps
// Function
// - voltage register holds 7-bit code, parity bit7
// - voltage code resets to 0110010
// - control-source bit resets external; 1 uses code
// - writing control-source 0 returns external anytime
// - masking bit disables protection during code change
// - light-load bit 0 PFM, 1 PWM, default PWM
// - protection bit 0 auto-recover, 1 latch-off default
// - bad parity: no acknowledge, code kept
// - erroneous control write keeps previous contents
// - reads return stored parity; master retries rejected writes
// - bus inputs suppress spikes of 32 ns
// - address match acknowledged on ninth clock
// - address mismatch: no acknowledge, wait next START
// - read sends eight bits, idle after STOP
module vcr_i2c_bank #(
  parameter logic [6:0] SLAVE_ADDR = vcr_pkg::SLAVE_ADDR_DEF
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  input  wire logic       output_voltage_code_ramp_busy_i,
  output logic [6:0]      output_voltage_code_o,
  output logic            internal_mode_o,
  output logic            protect_off_o,
  output logic            light_load_pwm_select_o,
  output logic            latch_off_o
);
  logic                 scl_f;
  logic                 sda_f;
  logic                 scl_q;
  logic                 sda_q;
  logic                 scl_rise;
  logic                 scl_fall;
  logic                 start_det;
  logic                 stop_det;
  vcr_pkg::vcr_state_t  state;
  vcr_pkg::vcr_state_t  next_state;
  logic [3:0]           bit_cnt;
  logic [3:0]           next_bit_cnt;
  logic [7:0]           shift;
  logic [7:0]           next_shift;
  logic [7:0]           ptr;
  logic [7:0]           next_ptr;
  logic                 rw;
  logic                 next_rw;
  logic                 next_sda_oe;
  logic                 next_protect_off;
  logic                 wr_accept;
  logic [7:0]           rd_data;
  logic [7:0]           output_voltage_code_reg;
  vcr_pkg::vcr_wr_t     wr;
  vcr_pkg::vcr_ctrl_t   ctrl;

  vcr_pin_filter u_scl_filt (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .pin_i   (scl_i),
    .filt_o  (scl_f)
  );

  vcr_pin_filter u_sda_filt (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .pin_i   (sda_i),
    .filt_o  (sda_f)
  );

  vcr_regs u_regs (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .wr_i        (wr),
    .rd_addr_i   (ptr),
    .wr_accept_o (wr_accept),
    .rd_data_o   (rd_data),
    .output_voltage_code_reg_o  (output_voltage_code_reg),
    .ctrl_o      (ctrl)
  );

  // open drain: only ever pulls low
  assign sda_o = 1'b0;

  always_comb begin
    scl_rise  = scl_f & ~scl_q;
    scl_fall  = ~scl_f & scl_q;
    start_det = scl_f & scl_q & sda_q & ~sda_f;
    stop_det  = scl_f & scl_q & ~sda_q & sda_f;
  end

  always_comb begin
    next_state   = state;
    next_bit_cnt = bit_cnt;
    next_shift   = shift;
    next_ptr     = ptr;
    next_rw      = rw;
    next_sda_oe  = sda_oe_o;
    wr.en        = 1'b0;
    wr.addr      = ptr;
    wr.data      = shift;
    if (stop_det) begin
      next_state  = vcr_pkg::S_IDLE;
      next_sda_oe = 1'b0;
    end else if (start_det) begin
      next_state   = vcr_pkg::S_ADDR;
      next_bit_cnt = 4'h0;
      next_sda_oe  = 1'b0;
    end else begin
      case (state)
        vcr_pkg::S_ADDR, vcr_pkg::S_PTR, vcr_pkg::S_WDATA: begin
          if (scl_rise && bit_cnt != 4'h8) begin
            next_shift   = {shift[6:0], sda_f};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            next_bit_cnt = 4'h0;
            if (state == vcr_pkg::S_ADDR) begin
              if (shift[7:1] == SLAVE_ADDR) begin
                next_rw     = shift[0];
                next_sda_oe = 1'b1;
                next_state  = vcr_pkg::S_AACK;
              end else begin
                next_state  = vcr_pkg::S_IGNORE;
              end
            end else if (state == vcr_pkg::S_PTR) begin
              next_ptr    = shift;
              next_sda_oe = 1'b1;
              next_state  = vcr_pkg::S_PACK;
            end else begin
              wr.en       = 1'b1;
              next_sda_oe = wr_accept;
              next_state  = vcr_pkg::S_DACK;
            end
          end
        end
        vcr_pkg::S_AACK: begin
          if (scl_fall) begin
            if (rw) begin
              next_shift  = rd_data;
              next_sda_oe = ~rd_data[7];
              next_state  = vcr_pkg::S_RDATA;
            end else begin
              next_sda_oe = 1'b0;
              next_state  = vcr_pkg::S_PTR;
            end
          end
        end
        vcr_pkg::S_PACK: begin
          if (scl_fall) begin
            next_sda_oe = 1'b0;
            next_state  = vcr_pkg::S_WDATA;
          end
        end
        vcr_pkg::S_DACK: begin
          if (scl_fall) begin
            next_sda_oe = 1'b0;
            // after a refusal the master must start over
            next_state  = sda_oe_o ? vcr_pkg::S_WDATA : vcr_pkg::S_IGNORE;
          end
        end
        vcr_pkg::S_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt == 4'h7) begin
              next_bit_cnt = 4'h0;
              next_sda_oe  = 1'b0;
              next_state   = vcr_pkg::S_RACK;
            end else begin
              next_bit_cnt = bit_cnt + 4'h1;
              next_shift   = {shift[6:0], 1'b0};
              next_sda_oe  = ~shift[6];
            end
          end
        end
        vcr_pkg::S_RACK: begin
          // master acknowledge is not looked at; one byte per read
          if (scl_fall) begin
            next_state = vcr_pkg::S_IGNORE;
          end
        end
        vcr_pkg::S_IDLE, vcr_pkg::S_IGNORE: begin
          next_sda_oe = 1'b0;
        end
        default: begin
          next_state  = vcr_pkg::S_IDLE;
          next_sda_oe = 1'b0;
        end
      endcase
    end
    // masking only applies while the analog loop reports a code move
    next_protect_off = ctrl.prot_mask & output_voltage_code_ramp_busy_i;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_q         <= 1'b1;
      sda_q         <= 1'b1;
      state         <= vcr_pkg::S_IDLE;
      bit_cnt       <= 4'h0;
      shift         <= 8'h00;
      ptr           <= 8'h00;
      rw            <= 1'b0;
      sda_oe_o      <= 1'b0;
      protect_off_o <= 1'b0;
    end else begin
      scl_q         <= scl_f;
      sda_q         <= sda_f;
      state         <= next_state;
      bit_cnt       <= next_bit_cnt;
      shift         <= next_shift;
      ptr           <= next_ptr;
      rw            <= next_rw;
      sda_oe_o      <= next_sda_oe;
      protect_off_o <= next_protect_off;
    end
  end

  always_comb begin
    output_voltage_code_o   = output_voltage_code_reg[6:0];
    internal_mode_o         = ctrl.internal_mode;
    light_load_pwm_select_o = ctrl.pwm_select;
    latch_off_o             = ctrl.latch_off;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_addr_ack: assert property (
    (state == vcr_pkg::S_ADDR && scl_fall && bit_cnt == 4'h8 && shift[7:1] == SLAVE_ADDR
     && !start_det && !stop_det) |=> sda_oe_o && state == vcr_pkg::S_AACK)
    else $error("matching address not acknowledged");

  a_addr_nack: assert property (
    (state == vcr_pkg::S_ADDR && scl_fall && bit_cnt == 4'h8 && shift[7:1] != SLAVE_ADDR
     && !start_det && !stop_det) |=> !sda_oe_o && state == vcr_pkg::S_IGNORE)
    else $error("foreign address answered");

  a_ignore_quiet: assert property (
    (state == vcr_pkg::S_IGNORE) |-> !sda_oe_o)
    else $error("bus driven while ignoring traffic");

  a_par_reject: assert property (
    (wr.en && wr.addr == vcr_pkg::REG_OUTPUT_VOLTAGE_CODE_ADDR && wr.data[7] != ~^wr.data[6:0])
    |=> !sda_oe_o && $stable(output_voltage_code_reg) ##1 $stable(output_voltage_code_reg))
    else $error("bad parity byte acknowledged or stored");

  a_par_accept: assert property (
    (wr.en && wr.addr == vcr_pkg::REG_OUTPUT_VOLTAGE_CODE_ADDR && wr.data[7] == ~^wr.data[6:0])
    |=> sda_oe_o && output_voltage_code_reg == $past(wr.data))
    else $error("good parity byte not taken");

  a_ctrl_bad_ptr: assert property (
    (wr.en && wr.addr > vcr_pkg::REG_CTRL_ADDR) |=> !sda_oe_o && $stable(ctrl))
    else $error("write to unmapped pointer changed state");

  a_read_release: assert property (
    (state == vcr_pkg::S_RDATA && scl_fall && bit_cnt == 4'h7 && !start_det && !stop_det)
    |=> !sda_oe_o && state == vcr_pkg::S_RACK)
    else $error("line not released after eight read bits");

  a_stop_idle: assert property (
    stop_det |=> state == vcr_pkg::S_IDLE && !sda_oe_o)
    else $error("STOP did not return to idle");

  a_prot_on: assert property (
    !ctrl.prot_mask |=> !protect_off_o)
    else $error("protection masked with masking bit clear");

  a_int_mode: assert property (
    (wr.en && wr.addr == vcr_pkg::REG_CTRL_ADDR && !wr.data[7]) |=> !internal_mode_o)
    else $error("control source did not return to external");

endmodule // vcr_i2c_bank

/* File: rtl/vcr_pkg.sv */
package vcr_pkg;

  // register pointers as seen on the bus
  localparam logic [7:0] REG_OUTPUT_VOLTAGE_CODE_ADDR = 8'h00;
  localparam logic [7:0] REG_CTRL_ADDR = 8'h01;

  // output voltage register layout
  localparam int         OUTPUT_VOLTAGE_CODE_PAR_BIT  = 7;
  localparam logic [6:0] OUTPUT_VOLTAGE_CODE_RESET    = 7'h32;

  // control register layout
  localparam int         CTRL_INT_BIT   = 7;
  localparam int         CTRL_MASK_BIT  = 4;
  localparam int         CTRL_PWM_BIT   = 3;
  localparam int         CTRL_LATCH_BIT = 0;
  localparam logic [7:0] CTRL_USED_MASK = 8'h99;
  localparam logic [7:0] CTRL_RESET     = 8'h09;

  // default 7-bit bus address
  localparam logic [6:0] SLAVE_ADDR_DEF = 7'h34;

  // spike suppression: least time, rounded up to whole clocks
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SPIKE_NS      = 32;
  localparam int SPIKE_CYC     = (SPIKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef struct packed {
    logic internal_mode;
    logic prot_mask;
    logic pwm_select;
    logic latch_off;
  } vcr_ctrl_t;

  typedef struct packed {
    logic       en;
    logic [7:0] addr;
    logic [7:0] data;
  } vcr_wr_t;

  typedef enum logic [3:0] {
    S_IDLE   = 4'h0,
    S_ADDR   = 4'h1,
    S_AACK   = 4'h2,
    S_PTR    = 4'h3,
    S_PACK   = 4'h4,
    S_WDATA  = 4'h5,
    S_DACK   = 4'h6,
    S_RDATA  = 4'h7,
    S_RACK   = 4'h8,
    S_IGNORE = 4'h9
  } vcr_state_t;

endpackage

/* File: rtl/vcr_pin_filter.sv */
`timescale 1ns/1ps
module vcr_pin_filter #(
  parameter int STABLE_CYC = vcr_pkg::SPIKE_CYC
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic pin_i,
  output logic      filt_o
);
  localparam int CW = $clog2(STABLE_CYC + 1);

  logic          sync0;
  logic          sync1;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic          next_filt;

  // a level change is taken only after it has held for STABLE_CYC clocks
  always_comb begin
    next_cnt  = '0;
    next_filt = filt_o;
    if (sync1 != filt_o) begin
      if (cnt == CW'(STABLE_CYC - 1)) begin
        next_filt = sync1;
      end else begin
        next_cnt = cnt + CW'(1);
      end
    end
  end

  // idle bus level is high, so both synchronisers and the output reset high; the counter resets to zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync0  <= 1'b1;
      sync1  <= 1'b1;
      cnt    <= '0;
      filt_o <= 1'b1;
    end else begin
      sync0  <= pin_i;
      sync1  <= sync0;
      cnt    <= next_cnt;
      filt_o <= next_filt;
    end
  end

  a_spike_block: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $changed(filt_o) |-> $past(cnt) == CW'(STABLE_CYC - 1))
    else $error("filtered level changed before the spike window elapsed");

endmodule // vcr_pin_filter

/* File: rtl/vcr_regs.sv */
`timescale 1ns/1ps
module vcr_regs (
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  input  wire vcr_pkg::vcr_wr_t   wr_i,
  input  wire logic [7:0]         rd_addr_i,
  output logic                    wr_accept_o,
  output logic [7:0]              rd_data_o,
  output logic [7:0]              output_voltage_code_reg_o,
  output vcr_pkg::vcr_ctrl_t      ctrl_o
);
  logic [7:0] ctrl_reg;
  logic [7:0] next_output_voltage_code;
  logic [7:0] next_ctrl;
  logic [7:0] next_rd;
  logic       par_ok;

  always_comb begin
    par_ok      = wr_i.data[vcr_pkg::OUTPUT_VOLTAGE_CODE_PAR_BIT] == ~^wr_i.data[6:0];
    wr_accept_o = ((wr_i.addr == vcr_pkg::REG_OUTPUT_VOLTAGE_CODE_ADDR) && par_ok)
                || (wr_i.addr == vcr_pkg::REG_CTRL_ADDR);
    next_output_voltage_code   = output_voltage_code_reg_o;
    next_ctrl   = ctrl_reg;
    if (wr_i.en && wr_accept_o) begin
      if (wr_i.addr == vcr_pkg::REG_OUTPUT_VOLTAGE_CODE_ADDR) begin
        next_output_voltage_code = wr_i.data;
      end else begin
        next_ctrl = wr_i.data & vcr_pkg::CTRL_USED_MASK;
      end
    end
    // a refused write leaves both registers as they were
    case (rd_addr_i)
      vcr_pkg::REG_OUTPUT_VOLTAGE_CODE_ADDR: next_rd = output_voltage_code_reg_o;
      vcr_pkg::REG_CTRL_ADDR: next_rd = ctrl_reg;
      default:                next_rd = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      output_voltage_code_reg_o <= {1'b0, vcr_pkg::OUTPUT_VOLTAGE_CODE_RESET};
      ctrl_reg   <= vcr_pkg::CTRL_RESET;
      rd_data_o  <= 8'h00;
    end else begin
      output_voltage_code_reg_o <= next_output_voltage_code;
      ctrl_reg   <= next_ctrl;
      rd_data_o  <= next_rd;
    end
  end

  always_comb begin
    ctrl_o.internal_mode = ctrl_reg[vcr_pkg::CTRL_INT_BIT];
    ctrl_o.prot_mask     = ctrl_reg[vcr_pkg::CTRL_MASK_BIT];
    ctrl_o.pwm_select    = ctrl_reg[vcr_pkg::CTRL_PWM_BIT];
    ctrl_o.latch_off     = ctrl_reg[vcr_pkg::CTRL_LATCH_BIT];
  end

  a_ctrl_unused: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ctrl_reg & ~vcr_pkg::CTRL_USED_MASK) == 8'h00)
    else $error("unused control bits are not zero");

  a_output_voltage_code_parity: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $changed(output_voltage_code_reg_o) |-> output_voltage_code_reg_o[7] == ~^output_voltage_code_reg_o[6:0])
    else $error("stored voltage code with bad parity");

endmodule // vcr_regs

/* File: test/vcr_bus_master.sv */
`timescale 1ns/1ps
module vcr_bus_master #(
  parameter int Q = 20
) (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  // scl stands high between frames; a released sda floats up to its pull-up
  initial begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // raises scl before the start edge, so it also serves as a repeated start when entered with scl low
  task automatic start();
    sda_low_o = 1'b0;
    wt(Q);
    scl_o = 1'b1;
    wt(Q);
    sda_low_o = 1'b1;
    wt(Q);
    scl_o = 1'b0;
    wt(Q);
  endtask

  task automatic stop();
    sda_low_o = 1'b1;
    wt(Q);
    scl_o = 1'b1;
    wt(Q);
    sda_low_o = 1'b0;
    wt(2 * Q);
  endtask

  // gl puts a 25 ns scl spike ahead of every bit; sda is held so no start or stop forms
  task automatic send(input logic [7:0] b, input logic gl, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      if (gl) begin
        scl_o = 1'b1;
        wt(5);
        scl_o = 1'b0;
      end
      sda_low_o = ~b[i];
      wt(Q);
      scl_o = 1'b1;
      wt(2 * Q);
      scl_o = 1'b0;
      wt(Q);
    end
    sda_low_o = 1'b0;
    wt(Q);
    scl_o = 1'b1;
    wt(Q);
    ack = ~sda_i;
    wt(Q);
    scl_o = 1'b0;
    wt(Q);
  endtask

  task automatic recv(input logic mack, output logic [7:0] b);
    sda_low_o = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      wt(Q);
      scl_o = 1'b1;
      wt(Q);
      b[i] = sda_i;
      wt(Q);
      scl_o = 1'b0;
    end
    wt(Q);
    sda_low_o = mack;
    wt(Q);
    scl_o = 1'b1;
    wt(2 * Q);
    scl_o = 1'b0;
    wt(Q);
  endtask
endmodule // vcr_bus_master

/* File: test/tb.sv */
`timescale 1ns/1ps
module tb;
  localparam logic [6:0] ADDR = vcr_pkg::SLAVE_ADDR_DEF;
  logic       clk_i   = 1'b0;
  logic       rst_n_i = 1'b0;
  logic       busy    = 1'b0;
  logic       scl;
  logic       m_low;
  logic       sda_o;
  logic       sda_oe;
  logic       sda;
  logic [6:0] code;
  logic       intm;
  logic       poff;
  logic       pwm;
  logic       latch;
  logic [2:0] ak;
  logic [7:0] d;
  int         err_count = 0;
  int         checks    = 0;

  always #2.5 clk_i = ~clk_i;
  // open-drain wire with pull-up
  assign sda = ~(m_low | (sda_oe & ~sda_o));

  vcr_bus_master #(.Q(20)) i_master (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low));

  vcr_i2c_bank i_dut (
    .clk_i                  (clk_i),
    .rst_n_i                (rst_n_i),
    .scl_i                  (scl),
    .sda_i                  (sda),
    .sda_o                  (sda_o),
    .sda_oe_o               (sda_oe),
    .output_voltage_code_ramp_busy_i       (busy),
    .output_voltage_code_o  (code),
    .internal_mode_o        (intm),
    .protect_off_o          (poff),
    .light_load_pwm_select_o(pwm),
    .latch_off_o            (latch)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  function automatic logic [7:0] vbyte(input logic [6:0] c);
    return {~^c, c};
  endfunction

  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] v, input logic gl);
    i_master.start();
    i_master.send({a, 1'b0}, 1'b0, ak[2]);
    i_master.send(p, gl, ak[1]);
    i_master.send(v, 1'b0, ak[0]);
    i_master.stop();
  endtask

  task automatic rd(input logic [7:0] p, input logic mack);
    logic [2:0] a3;
    i_master.start();
    i_master.send({ADDR, 1'b0}, 1'b0, a3[2]);
    i_master.send(p, 1'b0, a3[1]);
    i_master.start();
    i_master.send({ADDR, 1'b1}, 1'b0, a3[0]);
    i_master.recv(mack, d);
    i_master.stop();
    chk(a3, 3'h7);
    chk(sda_oe, 1'b0);
  endtask

  task automatic t_reset();
    chk({code, intm, poff, pwm, latch}, {7'h32, 4'h3});
    chk({sda_o, sda_oe}, 2'h0);
    rd(8'h00, 1'b1);
    chk(d, 8'h32);
    rd(8'h01, 1'b0);
    chk(d, 8'h09);
    $display("test reset done");
  endtask

  task automatic t_code();
    logic [6:0] cs [3] = '{7'h00, 7'h7F, 7'h55};
    foreach (cs[i]) begin
      wr(ADDR, 8'h00, vbyte(cs[i]), 1'b0);
      chk(ak, 3'h7);
      chk(code, cs[i]);
      rd(8'h00, 1'b1);
      chk(d, vbyte(cs[i]));
    end
    $display("test code write done");
  endtask

  task automatic t_parity();
    logic [6:0] cur;
    cur = code;
    wr(ADDR, 8'h00, vbyte(7'h10) ^ 8'h80, 1'b0);
    chk(ak, 3'h6);
    chk(code, cur);
    rd(8'h00, 1'b1);
    chk(d, vbyte(cur));
    wr(ADDR, 8'h00, vbyte(7'h10), 1'b0);
    chk(ak, 3'h7);
    chk(code, 7'h10);
    $display("test parity done");
  endtask

  task automatic t_ctrl();
    wr(ADDR, 8'h01, 8'hFF, 1'b0);
    rd(8'h01, 1'b1);
    chk(d, 8'h99);
    chk({intm, pwm, latch}, 3'h7);
    busy = 1'b1;
    i_master.wt(4);
    chk(poff, 1'b1);
    busy = 1'b0;
    i_master.wt(4);
    chk(poff, 1'b0);
    wr(ADDR, 8'h01, 8'h00, 1'b0);
    chk({intm, pwm, latch}, 3'h0);
    busy = 1'b1;
    i_master.wt(4);
    chk(poff, 1'b0);
    busy = 1'b0;
    rd(8'h01, 1'b1);
    chk(d, 8'h00);
    $display("test control done");
  endtask

  task automatic t_refuse();
    wr(ADDR, 8'h02, 8'h89, 1'b0);
    chk(ak, 3'h6);
    rd(8'h01, 1'b1);
    chk(d, 8'h00);
    wr(ADDR ^ 7'h01, 8'h01, 8'h89, 1'b0);
    chk(ak, 3'h0);
    chk({intm, pwm, latch}, 3'h0);
    wr(ADDR, 8'h01, 8'h09, 1'b0);
    chk(ak, 3'h7);
    chk({intm, pwm, latch}, 3'h3);
    $display("test refusals done");
  endtask

  task automatic t_spike();
    wr(ADDR, 8'h00, vbyte(7'h2A), 1'b1);
    chk(ak, 3'h7);
    chk(code, 7'h2A);
    $display("test spikes done");
  endtask

  initial begin
    repeat (100000) @(posedge clk_i);
    err_count++;
    end_sim();
  end

  initial begin
    repeat (16) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (20) @(negedge clk_i);
    t_reset();
    t_code();
    t_parity();
    t_ctrl();
    t_refuse();
    t_spike();
    end_sim();
  end
endmodule // tb
